// >>> core/pao_controller.sv
// controller end: sequences requests onto the pixel alu link
`timescale 1ns/1ns
module pao_controller
   import pao_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   pao_link_if.controller link,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire pao_kind_e cmdKind,
   input wire logic [5:0] cmdAddr,
   input wire logic [31:0] cmdData,
   input wire logic [3:0] cmdExt,
   input wire logic [5:0] cmdWaddr,
   output logic respValid,
   output logic [31:0] respData
);
   typedef enum logic [1:0] {
      C_IDLE = 2'h0,
      C_SETUP = 2'h1,
      C_WADDR = 2'h2
   } pao_cstate_e;
   typedef struct packed {
      pao_cstate_e state;
      logic steerShadow;
      logic [5:0] pendAddr;
      logic [5:0] pendWaddr;
      pao_kind_e kind;
      logic [5:0] addr;
      logic [31:0] data;
      logic [3:0] ext;
      logic respValid;
      logic [31:0] respData;
   } pao_ctrl_s;

   pao_ctrl_s q;
   pao_ctrl_s d;

   function automatic logic [31:0] regMask(input logic [5:0] idx);
      logic [31:0] m;
      m = 32'h00000000;
      case (idx)
         REG_STEER_IDX: m = STEER_WMASK;
         REG_BLEND2_IDX: m = BLEND2_WMASK;
         REG_PREBLEND_IDX: m = PREBLEND_WMASK;
         default: m = 32'h00000000;
      endcase
      return m;
   endfunction

   assign cmdReady = (q.state == C_IDLE);

   always_comb begin
      d = q;
      d.kind = KIND_IDLE;
      d.addr = 6'h00;
      d.data = 32'h00000000;
      d.ext = 4'h0;
      d.respValid = link.rdValid;
      d.respData = link.rdValid ? link.rdData : q.respData;
      case (q.state)
         C_IDLE: begin
            if (cmdValid) begin
               if (cmdKind == KIND_MOVE) begin
                  d.pendAddr = cmdAddr;
                  d.pendWaddr = cmdWaddr;
                  if (q.steerShadow) begin
                     d.kind = KIND_STATEFUL;
                     d.addr = cmdAddr;
                     d.state = C_WADDR;
                  end else begin
                     // steering must be on before the move's stateful write
                     d.kind = KIND_REG_WR;
                     d.addr = REG_STEER_IDX;
                     d.data = STEER_WMASK;
                     d.steerShadow = 1'b1;
                     d.state = C_SETUP;
                  end
               end else begin
                  d.kind = cmdKind;
                  d.addr = cmdAddr;
                  d.ext = cmdExt;
                  d.data = (cmdKind == KIND_REG_WR) ? (cmdData & regMask(cmdAddr)) : cmdData;
                  if (cmdKind == KIND_REG_WR && cmdAddr == REG_STEER_IDX) begin
                     d.steerShadow = cmdData[STEER_SEL_BIT];
                  end
               end
            end
         end
         C_SETUP: begin
            d.kind = KIND_STATEFUL;
            d.addr = q.pendAddr;
            d.state = C_WADDR;
         end
         C_WADDR: begin
            // write address rides bits 29:24 the cycle after the read address
            d.data[WADDR_LSB+5:WADDR_LSB] = q.pendWaddr;
            d.state = C_IDLE;
         end
         default: d.state = C_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign link.reqKind = q.kind;
   assign link.pixelBufferAddressPins = q.addr;
   assign link.pixelAluDataBus = q.data;
   assign link.dataExt = q.ext;
   assign respValid = q.respValid;
   assign respData = q.respData;
endmodule

// >>> core/pao_device.sv
// device end: pixel buffer write steering and blend operand selection
`timescale 1ns/1ns
// Overview of operation
// - steering bit picks pins or bus write address
// - controller writes steering reserved bits as zero
// - steering resets zero, ignored on stateless writes
// - move: read address, then write address; seven-cycle write
// - controller sets steering before scroll moves
// - four-bit secondary field per unit, byte spaced
// - bits 29:28 choose alpha-saturate output
// - per-unit bits pick second factor source
// - per-unit bit picks first factor source
// - per-unit bit picks addend source
// - controller zeroes secondary control reserved bits
// - secondary control resets zero, ignored when stateless
// - preblend takes first factor, addend from bus
// - one shared alpha-saturate, preblend selects it
// - preblend bits pick preblend second factor
// - preblend bit picks looped back addend
// - controller zeroes preblend control reserved bits
// - preblend control resets zero, ignored when stateless
// - new operand from bus or constant byte
module pao_device
   import pao_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   pao_link_if.device link,
   input wire logic [31:0] ropBlendControl,
   input wire logic [31:0] constantSource,
   input wire logic [3:0] constantExt,
   output logic [NUM_UNITS-1:0][8:0] firstFactor,
   output logic [NUM_UNITS-1:0][8:0] secondFactor,
   output logic [NUM_UNITS-1:0][7:0] addend,
   output logic [NUM_UNITS-1:0] loopAddend,
   output logic opValid,
   output logic preblendCycle,
   output logic pbWrEn,
   output logic [5:0] pbWrAddr,
   output logic [31:0] pbWrData
);
   typedef struct packed {
      logic [31:0] steer;
      logic [31:0] blend2;
      logic [31:0] preblend;
      logic [PB_DEPTH-1:0][31:0] pbuf;
      pao_stage_s [MOVE_DELAY-1:0] pipe;
      logic [NUM_UNITS-1:0][8:0] f1;
      logic [NUM_UNITS-1:0][8:0] f2;
      logic [NUM_UNITS-1:0][7:0] add;
      logic [NUM_UNITS-1:0] loopAdd;
      logic opValid;
      logic pre;
      logic wrEn;
      logic [5:0] wrAddr;
      logic [31:0] wrData;
      logic rdValid;
      logic [31:0] rdData;
   } pao_dev_s;

   pao_dev_s q;
   pao_dev_s d;
   logic stateless;
   logic isPre;
   logic [31:0] effSteer;
   logic [31:0] effBlend2;
   logic [31:0] effPre;
   logic [31:0] oldWord;
   logic [NUM_UNITS-1:0][7:0] newByte;
   logic [7:0] asatNorm;
   logic [7:0] asatPre;
   logic [NUM_UNITS-1:0][8:0] f1Calc;
   logic [NUM_UNITS-1:0][8:0] f2Calc;
   logic [NUM_UNITS-1:0][7:0] addCalc;
   logic [NUM_UNITS-1:0] loopCalc;

   function automatic logic [7:0] alphaSat(input logic [1:0] sel, input logic [7:0] nw,
                                           input logic [7:0] od);
      logic [7:0] res;
      res = 8'h00;
      case (sel)
         ASAT_MIN: res = (nw < ~od) ? nw : ~od;
         ASAT_NEW: res = nw;
         ASAT_OLD: res = od;
         ASAT_INV_OLD: res = ~od;
         default: res = 8'h00;
      endcase
      return res;
   endfunction

   // stateless writes see all three registers as zero
   assign stateless = (link.reqKind == KIND_STATELESS);
   assign isPre = (link.reqKind == KIND_PREBLEND);
   assign effSteer = stateless ? 32'h00000000 : q.steer;
   assign effBlend2 = stateless ? 32'h00000000 : q.blend2;
   assign effPre = stateless ? 32'h00000000 : q.preblend;
   // no forwarding: a read of a word still in the move pipe returns the stale value
   assign oldWord = q.pbuf[link.pixelBufferAddressPins];

   // single alpha-saturate block sits in unit 3 and feeds all units
   assign asatNorm = alphaSat(effBlend2[ASAT_LSB+1:ASAT_LSB], newByte[3], oldWord[31:24]);
   assign asatPre = alphaSat(effPre[ASAT_LSB+1:ASAT_LSB], newByte[3], oldWord[31:24]);

   genvar n;
   generate
      for (n = 0; n < NUM_UNITS; n++) begin : gUnit
         logic [7:0] busB;
         logic [7:0] constB;
         logic [7:0] oldB;
         logic [7:0] b2Field;
         logic [7:0] pbField;
         logic [1:0] f2Sel;
         logic [7:0] asatSel;
         logic [8:0] ropF1;
         assign busB = link.pixelAluDataBus[8*n+7:8*n];
         assign constB = constantSource[8*n+7:8*n];
         assign oldB = oldWord[8*n+7:8*n];
         assign b2Field = effBlend2[8*n+7:8*n];
         assign pbField = effPre[8*n+7:8*n];
         assign newByte[n] = ropBlendControl[8*n+RBC_NEW_BIT] ? constB : busB;
         always_comb begin
            case (pao_f1src_e'(ropBlendControl[8*n+RBC_F1_LSB+1:8*n+RBC_F1_LSB]))
               F1_ONE: ropF1 = FACTOR_ONE;
               F1_CONST: ropF1 = {constantExt[n], constB};
               F1_BUS: ropF1 = {link.dataExt[n], busB};
               F1_BUS3: ropF1 = {link.dataExt[3], link.pixelAluDataBus[31:24]};
               default: ropF1 = FACTOR_ONE;
            endcase
         end
         assign f2Sel = isPre ? pbField[F2SEL_LSB+1:F2SEL_LSB] :
                                b2Field[F2SEL_LSB+1:F2SEL_LSB];
         assign asatSel = isPre ? asatPre : asatNorm;
         // second factor: old, inverted old or shared alpha-saturate
         assign f2Calc[n] = f2Sel[1] ? {1'b0, asatSel} :
                            f2Sel[0] ? {1'b0, ~oldB} : {1'b0, oldB};
         // preblend pins both first factor and addend to the bus byte
         assign f1Calc[n] = isPre ? {1'b0, busB} :
                            b2Field[F1SEL_BIT] ? {1'b0, oldB} : ropF1;
         assign addCalc[n] = isPre ? busB :
                             b2Field[ADDSEL_BIT] ? oldB : newByte[n];
         assign loopCalc[n] = isPre & pbField[LOOPSEL_BIT];
      end
   endgenerate

   always_comb begin
      pao_stage_s st;
      st.valid = (link.reqKind == KIND_STATEFUL) || stateless;
      st.move = (link.reqKind == KIND_STATEFUL) && effSteer[STEER_SEL_BIT];
      st.waddr = link.pixelBufferAddressPins;
      st.data = st.move ? oldWord : link.pixelAluDataBus;
      d = q;
      d.pipe = {q.pipe[MOVE_DELAY-2:0], st};
      // a move learns its write address from the bus one cycle after the request
      if (q.pipe[0].valid && q.pipe[0].move) begin
         d.pipe[1].waddr = link.pixelAluDataBus[WADDR_LSB+5:WADDR_LSB];
      end
      d.wrEn = q.pipe[MOVE_DELAY-1].valid;
      d.wrAddr = q.pipe[MOVE_DELAY-1].waddr;
      d.wrData = q.pipe[MOVE_DELAY-1].data;
      if (q.pipe[MOVE_DELAY-1].valid) begin
         d.pbuf[q.pipe[MOVE_DELAY-1].waddr] = q.pipe[MOVE_DELAY-1].data;
      end
      d.opValid = st.valid || isPre;
      d.pre = isPre;
      if (st.valid || isPre) begin
         d.f1 = f1Calc;
         d.f2 = f2Calc;
         d.add = addCalc;
         d.loopAdd = loopCalc;
      end
      // reserved bits are dropped so they always read back as zero
      if (link.reqKind == KIND_REG_WR) begin
         case (link.pixelBufferAddressPins)
            REG_STEER_IDX: d.steer = link.pixelAluDataBus & STEER_WMASK;
            REG_BLEND2_IDX: d.blend2 = link.pixelAluDataBus & BLEND2_WMASK;
            REG_PREBLEND_IDX: d.preblend = link.pixelAluDataBus & PREBLEND_WMASK;
            default: d.steer = q.steer;
         endcase
      end
      d.rdValid = (link.reqKind == KIND_REG_RD);
      d.rdData = 32'h00000000;
      if (link.reqKind == KIND_REG_RD) begin
         case (link.pixelBufferAddressPins)
            REG_STEER_IDX: d.rdData = q.steer;
            REG_BLEND2_IDX: d.rdData = q.blend2;
            REG_PREBLEND_IDX: d.rdData = q.preblend;
            default: d.rdData = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.steer <= STEER_RESET;
         q.blend2 <= BLEND2_RESET;
         q.preblend <= PREBLEND_RESET;
      end else begin
         q <= d;
      end
   end

   assign firstFactor = q.f1;
   assign secondFactor = q.f2;
   assign addend = q.add;
   assign loopAddend = q.loopAdd;
   assign opValid = q.opValid;
   assign preblendCycle = q.pre;
   assign pbWrEn = q.wrEn;
   assign pbWrAddr = q.wrAddr;
   assign pbWrData = q.wrData;
   assign link.rdValid = q.rdValid;
   assign link.rdData = q.rdData;
endmodule

// >>> core/pao_link_if.sv
// link between rendering controller and pixel alu port
`timescale 1ns/1ns
interface pao_link_if;
   import pao_pkg::*;
   pao_kind_e reqKind;
   logic [5:0] pixelBufferAddressPins;
   logic [31:0] pixelAluDataBus;
   logic [3:0] dataExt;
   logic rdValid;
   logic [31:0] rdData;
   modport device (
      input reqKind,
      input pixelBufferAddressPins,
      input pixelAluDataBus,
      input dataExt,
      output rdValid,
      output rdData
   );
   modport controller (
      output reqKind,
      output pixelBufferAddressPins,
      output pixelAluDataBus,
      output dataExt,
      input rdValid,
      input rdData
   );
endinterface

// >>> core/pao_pkg.sv
// shared constants and types for the pixel alu operand select link
package pao_pkg;
   localparam int NUM_UNITS = 4;
   localparam int PB_DEPTH = 64;
   localparam int MOVE_DELAY = 7;
   localparam logic [5:0] REG_STEER_IDX = 6'h00;
   localparam logic [5:0] REG_BLEND2_IDX = 6'h01;
   localparam logic [5:0] REG_PREBLEND_IDX = 6'h02;
   localparam logic [31:0] STEER_RESET = 32'h00000000;
   localparam logic [31:0] BLEND2_RESET = 32'h00000000;
   localparam logic [31:0] PREBLEND_RESET = 32'h00000000;
   localparam logic [31:0] STEER_WMASK = 32'h00000001;
   localparam logic [31:0] BLEND2_WMASK = 32'h3f0f0f0f;
   localparam logic [31:0] PREBLEND_WMASK = 32'h3d0d0d0d;
   localparam int STEER_SEL_BIT = 0;
   localparam int WADDR_LSB = 24;
   localparam int ASAT_LSB = 28;
   localparam int F2SEL_LSB = 2;
   localparam int F1SEL_BIT = 1;
   localparam int ADDSEL_BIT = 0;
   localparam int LOOPSEL_BIT = 0;
   localparam int RBC_F1_LSB = 6;
   localparam int RBC_NEW_BIT = 5;
   localparam logic [8:0] FACTOR_ONE = 9'h100;
   typedef enum logic [2:0] {
      KIND_IDLE = 3'h0,
      KIND_STATEFUL = 3'h1,
      KIND_STATELESS = 3'h2,
      KIND_PREBLEND = 3'h3,
      KIND_REG_WR = 3'h4,
      KIND_REG_RD = 3'h5,
      KIND_MOVE = 3'h6
   } pao_kind_e;
   typedef enum logic [1:0] {
      ASAT_MIN = 2'h0,
      ASAT_NEW = 2'h1,
      ASAT_OLD = 2'h2,
      ASAT_INV_OLD = 2'h3
   } pao_asat_e;
   typedef enum logic [1:0] {
      F1_ONE = 2'h0,
      F1_CONST = 2'h1,
      F1_BUS = 2'h2,
      F1_BUS3 = 2'h3
   } pao_f1src_e;
   typedef struct packed {
      logic valid;
      logic move;
      logic [5:0] waddr;
      logic [31:0] data;
   } pao_stage_s;
endpackage

// >>> dv/pao_props.sv
// link checker for the pixel alu operand select pair
`timescale 1ns/1ns
module pao_props
   import pao_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire pao_kind_e reqKind,
   input wire logic [5:0] pixelBufferAddressPins,
   input wire logic [31:0] pixelAluDataBus,
   input wire logic [3:0] dataExt,
   input wire logic rdValid,
   input wire logic [31:0] rdData
);
   logic [31:0] regs_q [3];
   logic wr;
   logic rd;
   logic [5:0] ix;
   logic [31:0] bus;
   assign ix = pixelBufferAddressPins;
   assign bus = pixelAluDataBus;
   assign wr = reqKind == KIND_REG_WR;
   assign rd = reqKind == KIND_REG_RD;
   // mirror of what the controller wrote; masking is checked on its own
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         regs_q <= '{default: '0};
      end else if (wr && ix < 6'h03) begin
         regs_q[ix[1:0]] <= bus;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_rd_ans;
      rd |=> rdValid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_steer_rd;
      rd && ix == REG_STEER_IDX |=> rdData == regs_q[0];
   endproperty
   a_steer_rd: assert property (p_steer_rd) else $error("steer read wrong");
   property p_b2_rd;
      rd && ix == REG_BLEND2_IDX |=> rdData == regs_q[1];
   endproperty
   a_b2_rd: assert property (p_b2_rd) else $error("blend2 read wrong");
   property p_pre_rd;
      rd && ix == REG_PREBLEND_IDX |=> rdData == regs_q[2];
   endproperty
   a_pre_rd: assert property (p_pre_rd) else $error("preblend read wrong");
   property p_steer_rsv;
      wr && ix == REG_STEER_IDX |-> bus[31:1] == 31'h0;
   endproperty
   a_steer_rsv: assert property (p_steer_rsv) else $error("steer reserved set");
   property p_b2_rsv;
      wr && ix == REG_BLEND2_IDX |-> (bus & 32'hc0f0f0f0) == 32'h0;
   endproperty
   a_b2_rsv: assert property (p_b2_rsv) else $error("blend2 reserved set");
   property p_pre_rsv;
      wr && ix == REG_PREBLEND_IDX |-> (bus & 32'hc2f2f2f2) == 32'h0;
   endproperty
   a_pre_rsv: assert property (p_pre_rsv) else $error("preblend reserved set");
   property p_move_gap;
      reqKind == KIND_STATEFUL && regs_q[0][0] |=> reqKind == KIND_IDLE;
   endproperty
   a_move_gap: assert property (p_move_gap) else $error("move address slot busy");
   c_pre: cover property (reqKind == KIND_PREBLEND);
   c_move: cover property (reqKind == KIND_STATEFUL && regs_q[0][0]);
   c_rd: cover property (rdValid && rdData != 32'h0);
   c_move_setup: cover property (wr && ix == REG_STEER_IDX ##1 reqKind == KIND_STATEFUL);
endmodule

// >>> dv/tb.sv
// self-checking bench for the pixel alu operand select pair
`timescale 1ns/1ns
module tb;
   import pao_pkg::*;
   localparam logic [31:0] MSK [3] = '{32'h00000001, 32'h3f0f0f0f, 32'h3d0d0d0d};
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmdValid = 1'b0;
   pao_kind_e cmdKind = KIND_IDLE;
   logic [5:0] cmdAddr = 6'h00;
   logic [5:0] cmdWaddr = 6'h00;
   logic [31:0] cmdData = 32'h0;
   logic [3:0] cmdExt = 4'h0;
   logic [31:0] rop_blend_control = 32'h0;
   logic [31:0] kSrc = 32'h0;
   logic [3:0] kExt = 4'h0;
   logic cmdReady, respValid, opValid, preblendCycle, pbWrEn;
   logic [31:0] respData, pbWrData;
   logic [5:0] pbWrAddr;
   logic [3:0] loopAddend, ev;
   logic [NUM_UNITS-1:0][8:0] f1, f2;
   logic [NUM_UNITS-1:0][7:0] add;
   logic [31:0] mem [64];
   logic [31:0] regs [3];
   int num_errors = 0;
   int samples_checked = 0;
   int seed = 32'hcf12;
   int cyc = 0;
   assign ev = {respValid, pbWrEn, opValid, cmdReady};
   pao_link_if pao_link_if_i();
   pao_device pao_device_i(.ref_clk(ref_clk), .rst_b(rst_b), .link(pao_link_if_i),
      .ropBlendControl(rop_blend_control), .constantSource(kSrc), .constantExt(kExt), .firstFactor(f1),
      .secondFactor(f2), .addend(add), .loopAddend(loopAddend), .opValid(opValid),
      .preblendCycle(preblendCycle), .pbWrEn(pbWrEn), .pbWrAddr(pbWrAddr), .pbWrData(pbWrData));
   pao_controller pao_controller_i(.ref_clk(ref_clk), .rst_b(rst_b), .link(pao_link_if_i),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdAddr(cmdAddr),
      .cmdData(cmdData), .cmdExt(cmdExt), .cmdWaddr(cmdWaddr), .respValid(respValid),
      .respData(respData));
   pao_props pao_props_i(.ref_clk(ref_clk), .rst_b(rst_b), .reqKind(pao_link_if_i.reqKind),
      .pixelBufferAddressPins(pao_link_if_i.pixelBufferAddressPins),
      .pixelAluDataBus(pao_link_if_i.pixelAluDataBus), .dataExt(pao_link_if_i.dataExt),
      .rdValid(pao_link_if_i.rdValid), .rdData(pao_link_if_i.rdData));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) cyc++;
   task automatic wrap_up();
      $display("num_errors=%0d samples_checked=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait on one completion flag, sampled where it is settled
   task automatic waitfor(input int b);
      for (int i = 0; i < 30 && ev[b] !== 1'b1; i++) @(negedge ref_clk);
      if (ev[b] !== 1'b1) begin
         chk(ev[b], 1'b1);
         wrap_up();
      end
   endtask
   function automatic logic [7:0] by(input logic [31:0] v, input int n);
      return v[8*n +: 8];
   endfunction
   task automatic cmd(input pao_kind_e k, input logic [5:0] a, input logic [31:0] d,
         input logic [5:0] w);
      // one edge with valid low between commands, so valid is never reassigned in one step
      @(negedge ref_clk);
      waitfor(0);
      cmdValid = 1'b1;
      cmdKind = k;
      cmdAddr = a;
      cmdData = d;
      cmdWaddr = w;
      cmdExt = 4'($random(seed));
      @(negedge ref_clk);
      cmdValid = 1'b0;
   endtask
   task automatic regwr(input logic [5:0] i, input logic [31:0] d);
      cmd(KIND_REG_WR, i, d, 6'h00);
      if (i < 6'h03) regs[i[1:0]] = d & MSK[i[1:0]];
   endtask
   task automatic regrd(input logic [5:0] i);
      cmd(KIND_REG_RD, i, 32'h0, 6'h00);
      waitfor(3);
      chk(respData, i < 6'h03 ? regs[i[1:0]] : 32'h0);
   endtask
   task automatic chkops(input pao_kind_e k, input logic [31:0] d, input logic [31:0] o);
      logic [31:0] b, nw;
      logic [7:0] s, s2;
      logic [8:0] e1;
      b = k == KIND_STATEFUL ? regs[1] : k == KIND_PREBLEND ? regs[2] : 32'h0;
      for (int n = 0; n < 4; n++) nw[8*n +: 8] = rop_blend_control[8*n+5] ? by(kSrc, n) : by(d, n);
      case (b[29:28])
         2'h0: s = nw[31:24] < ~o[31:24] ? nw[31:24] : ~o[31:24];
         2'h1: s = nw[31:24];
         2'h2: s = o[31:24];
         default: s = ~o[31:24];
      endcase
      chk(preblendCycle, k == KIND_PREBLEND);
      for (int n = 0; n < 4; n++) begin
         case (rop_blend_control[8*n+6 +: 2])
            2'h0: e1 = FACTOR_ONE;
            2'h1: e1 = {kExt[n], by(kSrc, n)};
            2'h2: e1 = {cmdExt[n], by(d, n)};
            default: e1 = {cmdExt[3], d[31:24]};
         endcase
         s2 = b[8*n+3] ? s : b[8*n+2] ? ~by(o, n) : by(o, n);
         chk(f2[n], s2);
         if (k == KIND_PREBLEND) begin
            chk(f1[n][7:0], by(d, n));
            chk(add[n], by(d, n));
            chk(loopAddend[n], b[8*n]);
         end else begin
            chk(f1[n], b[8*n+1] ? {1'b0, by(o, n)} : e1);
            chk(add[n], b[8*n] ? by(o, n) : nw[8*n +: 8]);
         end
      end
   endtask
   task automatic op(input pao_kind_e k, input logic [5:0] a, input logic [5:0] w);
      logic [31:0] d, o;
      int t0;
      int lat;
      d = $random(seed);
      o = mem[a];
      rop_blend_control = $random(seed);
      kSrc = $random(seed);
      kExt = 4'($random(seed));
      // a move with steering off costs one extra link cycle for the steering write
      lat = (k == KIND_MOVE && regs[0][0] == 1'b0) ? 9 : 8;
      if (k == KIND_MOVE) regs[0] = 32'h00000001;
      cmd(k, a, d, w);
      t0 = cyc;
      if (k != KIND_MOVE) begin
         waitfor(1);
         chk(cyc - t0, 1);
         chkops(k, d, o);
      end
      if (k != KIND_PREBLEND) begin
         waitfor(2);
         chk(cyc - t0, lat);
         chk(pbWrAddr, k == KIND_MOVE ? w : a);
         chk(pbWrData, k == KIND_MOVE ? o : d);
         mem[k == KIND_MOVE ? w : a] = k == KIND_MOVE ? o : d;
      end
   endtask
   initial begin
      #1000000;
      chk(32'h0, 32'h1);
      wrap_up();
   end
   initial begin
      mem = '{default: 32'h0};
      regs = '{default: 32'h0};
      repeat (10) @(negedge ref_clk);
      rst_b = 1'b1;
      for (int i = 0; i < 4; i++) regrd(6'(i));
      for (int i = 0; i < 4; i++) begin
         regwr(6'(i), $random(seed));
         regrd(6'(i));
      end
      regwr(6'h00, 32'h0);
      for (int i = 0; i < 24; i++) begin
         regwr(6'h01, {2'h0, 2'(i), 28'($random(seed))});
         regwr(6'h02, {2'h0, 2'(i + 1), 28'($random(seed))});
         op(pao_kind_e'(i % 3 + 1), 6'($random(seed)), 6'h00);
      end
      op(KIND_STATEFUL, 6'h03, 6'h00);
      regwr(6'h00, 32'h1);
      op(KIND_MOVE, 6'h03, 6'h05);
      op(KIND_STATELESS, 6'h09, 6'h00);
      regwr(6'h00, 32'h0);
      op(KIND_STATEFUL, 6'h05, 6'h00);
      op(KIND_MOVE, 6'h05, 6'h0a);
      regrd(6'h00);
      wrap_up();
   end
endmodule
